/* File: rtl/dptmr_top.sv */
// Purpose: Two cascadable 16/32-bit timer pairs behind a Wishbone slave.
// Assumes: cpu_sleep and cpu_idle come from logic on ref_clk.
// Notes:   Pins pass two flops; two cycles of latency before edge logic.
`timescale 1ns/1ps
`default_nettype none
`include "dptmr_defs.svh"
module dptmr_top (
   input  wire logic                ref_clk,
   input  wire logic                srst,
   input  wire logic [11:0]         wb_adr_i,
   input  wire logic [31:0]         wb_dat_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic                wb_we_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic                cpu_sleep,
   input  wire logic                cpu_idle,
   input  wire logic                pair_a_ext_clock_pin,
   input  wire logic                pair_a_high_pin,
   input  wire logic                pair_b_low_pin,
   input  wire logic                pair_b_high_pin,
   output logic                     irq_o,
   output logic                     adc_trig_o,
   output dptmr_pkg::dptmr_word_t   tb_a_low_o,
   output dptmr_pkg::dptmr_word_t   tb_a_high_o
);
   import dptmr_pkg::*;

   logic [15:0] cnt_r  [4];
   logic [15:0] per_r  [4];
   logic [15:0] con_r  [4];
   logic [7:0]  ps_r   [4];
   logic [15:0] hold_r [2];
   logic [15:0] stat_r;
   logic [15:0] en_r;
   logic [15:0] rd_nxt;
   logic [31:0] dat_r;
   logic        ack_r;
   logic        trig_r;
   logic [3:0]  pin_s1_r;
   logic [3:0]  pin_s2_r;
   logic [3:0]  pin_s3_r;
   logic [3:0]  tick;
   logic [3:0]  fall;
   logic [3:0]  ev;
   logic [3:0]  wr_cnt;
   logic [3:0]  wr_con;
   logic [1:0]  m32;
   logic [1:0]  jn;
   logic [9:0]  idx;
   logic        wr_en;
   logic        rd_en;
   logic [15:0] wdat;

   // Register index of kind k (0 count, 1 period, 2 control, 3 hold)
   function automatic logic [9:0] reg_idx(input logic [1:0] k,
                                          input logic [1:0] t);
      case ({k, t})
         4'h0:    reg_idx = `DPT_IDX_A_LOW_CNT;
         4'h1:    reg_idx = `DPT_IDX_A_HIGH_CNT;
         4'h2:    reg_idx = `DPT_IDX_B_LOW_CNT;
         4'h3:    reg_idx = `DPT_IDX_B_HIGH_CNT;
         4'h4:    reg_idx = `DPT_IDX_A_LOW_PER;
         4'h5:    reg_idx = `DPT_IDX_A_HIGH_PER;
         4'h6:    reg_idx = `DPT_IDX_B_LOW_PER;
         4'h7:    reg_idx = `DPT_IDX_B_HIGH_PER;
         4'h8:    reg_idx = `DPT_IDX_A_LOW_CON;
         4'h9:    reg_idx = `DPT_IDX_A_HIGH_CON;
         4'ha:    reg_idx = `DPT_IDX_B_LOW_CON;
         4'hb:    reg_idx = `DPT_IDX_B_HIGH_CON;
         4'hc:    reg_idx = `DPT_IDX_A_HOLD;
         4'hd:    reg_idx = `DPT_IDX_B_HOLD;
         default: reg_idx = `DPT_IDX_NONE;
      endcase
   endfunction

   // Byte-lane merge of a 16-bit register write
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic [1:0]  sel);
      merge = {sel[1] ? nw[15:8] : old[15:8],
               sel[0] ? nw[7:0]  : old[7:0]};
   endfunction

   // Terminal count of the prescaler for a select code
   function automatic logic [7:0] ps_max(input dptmr_ps_t s);
      case (s)
         DPTMR_PS_1:   ps_max = `DPT_PS_T1;
         DPTMR_PS_8:   ps_max = `DPT_PS_T8;
         DPTMR_PS_64:  ps_max = `DPT_PS_T64;
         DPTMR_PS_256: ps_max = `DPT_PS_T256;
         default:      ps_max = `DPT_PS_T1;
      endcase
   endfunction

   // Bus decode; requests are taken in the cycle before ack
   assign idx   = wb_adr_i[11:2];
   assign wdat  = wb_dat_i[15:0];
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
   assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;

   // Ack follows the request by one cycle and drops right after
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      end
   end

   // Read data is captured with the request; unmapped reads give zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dat_r <= 32'h0000_0000;
      end else if (rd_en) begin
         dat_r <= {16'h0000, rd_nxt};
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // Read multiplexer
   always_comb begin
      rd_nxt = 16'h0000;
      for (int t = 0; t < 4; t++) begin
         if (idx == reg_idx(2'd0, 2'(t))) begin
            rd_nxt = cnt_r[t];
         end
         if (idx == reg_idx(2'd1, 2'(t))) begin
            rd_nxt = per_r[t];
         end
         if (idx == reg_idx(2'd2, 2'(t))) begin
            rd_nxt = con_r[t];
         end
      end
      for (int p = 0; p < 2; p++) begin
         if (idx == reg_idx(2'd3, 2'(p))) begin
            rd_nxt = hold_r[p];
         end
      end
      if (idx == `DPT_IDX_IRQ_STAT) begin
         rd_nxt = stat_r;
      end
      if (idx == `DPT_IDX_IRQ_EN) begin
         rd_nxt = en_r;
      end
   end

   // Pin synchronisers; s3 only serves edge detection on s2
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
         pin_s3_r <= 4'h0;
      end else begin
         pin_s1_r <= {pair_b_high_pin, pair_b_low_pin,
                      pair_a_high_pin, pair_a_ext_clock_pin};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // Per timer: control, period, prescaler and tick
   for (genvar t = 0; t < 4; t++) begin : g_tmr
      localparam int LO = t - (t % 2);
      logic [15:0] ctl;
      logic        run;
      logic        gated;
      logic        src_ev;
      logic [7:0]  pmax;
      logic [1:0]  src;

      assign wr_cnt[t] = wr_en && (idx == reg_idx(2'd0, 2'(t)));
      assign wr_con[t] = wr_en && (idx == reg_idx(2'd2, 2'(t)));
      // High half of a joined pair takes setup and pins of the low half
      assign ctl   = ((t % 2) == 1 && jn[t/2]) ? con_r[LO] : con_r[t];
      assign src   = ((t % 2) == 1 && jn[t/2]) ? 2'(LO) : 2'(t);
      // Sleep stops the instruction clock, so nothing advances
      assign run   = ctl[`DPT_BIT_ON] && !cpu_sleep &&
                     !(ctl[`DPT_BIT_IDLE] && cpu_idle);
      assign gated = ctl[`DPT_BIT_GATE] && !ctl[`DPT_BIT_CS];
      assign src_ev = ctl[`DPT_BIT_CS] ?
                      (pin_s2_r[src] && !pin_s3_r[src]) :
                      (gated ? pin_s2_r[src] : 1'b1);
      assign pmax    = ps_max(dptmr_ps_t'(ctl[`DPT_BIT_PS +: 2]));
      assign tick[t] = run && src_ev && (ps_r[t] == pmax);
      assign fall[t] = run && gated && !pin_s2_r[src] && pin_s3_r[src];

      // Prescaler clears on a write to the count or control
      always_ff @(posedge ref_clk) begin
         if (srst || wr_cnt[t] || wr_con[t]) begin
            ps_r[t] <= 8'h00;
         end else if (run && src_ev) begin
            ps_r[t] <= (ps_r[t] == pmax) ? 8'h00 : ps_r[t] + 8'h01;
         end
      end

      // Period register
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            per_r[t] <= `DPT_PER_RST;
         end else if (wr_en && idx == reg_idx(2'd1, 2'(t))) begin
            per_r[t] <= merge(per_r[t], wdat, wb_sel_i[1:0]);
         end
      end

      // Control register; the join bit exists in the low half only
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            con_r[t] <= `DPT_CON_RST;
         end else if (wr_con[t]) begin
            con_r[t] <= merge(con_r[t], wdat, wb_sel_i[1:0]) &
                        (((t % 2) == 0) ? `DPT_CON_MASK_LO : `DPT_CON_MASK_HI);
         end
      end

      // Nothing moves while asleep
      AST_SLEEP_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
         cpu_sleep && !wr_en |=> $stable(cnt_r[t]) && $stable(ps_r[t]))
         else $error("timer advanced during sleep");
      // Gate low in gated mode holds the count
      AST_GATE_STOP: assert property (@(posedge ref_clk) disable iff (srst)
         gated && !ctl[`DPT_BIT_CS] && !pin_s2_r[src] && !wr_en
         |=> $stable(cnt_r[t]))
         else $error("count moved with gate low");
   end

   // Per pair: low and high counts, holding register, events
   for (genvar p = 0; p < 2; p++) begin : g_pair
      localparam int LO = 2 * p;
      localparam int HI = 2 * p + 1;
      logic m_lo;
      logic m_hi;
      logic wr_hold;
      logic rd_lcnt;

      assign jn[p]   = con_r[LO][`DPT_BIT_JOIN];
      assign m_lo    = cnt_r[LO] == per_r[LO];
      assign m_hi    = cnt_r[HI] == per_r[HI];
      assign m32[p]  = m_lo && m_hi;
      assign wr_hold = wr_en && (idx == reg_idx(2'd3, 2'(p)));
      assign rd_lcnt = rd_en && (idx == reg_idx(2'd0, 2'(LO)));

      // Joined: events report on the high flag only
      assign ev[LO] = !jn[p] && ((tick[LO] && m_lo) || fall[LO]);
      assign ev[HI] = jn[p] ? ((tick[LO] && m32[p]) || fall[LO]) :
                      ((tick[HI] && m_hi) || fall[HI]);

      // Low count: least significant half when joined
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            cnt_r[LO] <= `DPT_CNT_RST;
         end else if (wr_cnt[LO]) begin
            cnt_r[LO] <= merge(cnt_r[LO], wdat, wb_sel_i[1:0]);
         end else if (tick[LO]) begin
            if (jn[p] ? m32[p] : m_lo) begin
               cnt_r[LO] <= 16'h0000;
            end else begin
               cnt_r[LO] <= cnt_r[LO] + 16'h0001;
            end
         end
      end

      // High count: carries from the low half when joined
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            cnt_r[HI] <= `DPT_CNT_RST;
         end else if (wr_cnt[LO] && jn[p]) begin
            cnt_r[HI] <= hold_r[p];
         end else if (wr_cnt[HI]) begin
            cnt_r[HI] <= merge(cnt_r[HI], wdat, wb_sel_i[1:0]);
         end else if (jn[p] && tick[LO]) begin
            if (m32[p]) begin
               cnt_r[HI] <= 16'h0000;
            end else if (cnt_r[LO] == 16'hffff) begin
               cnt_r[HI] <= cnt_r[HI] + 16'h0001;
            end
         end else if (!jn[p] && tick[HI]) begin
            cnt_r[HI] <= m_hi ? 16'h0000 : cnt_r[HI] + 16'h0001;
         end
      end

      // Holding register for coherent 32-bit access
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            hold_r[p] <= `DPT_CNT_RST;
         end else if (wr_hold) begin
            hold_r[p] <= merge(hold_r[p], wdat, wb_sel_i[1:0]);
         end else if (rd_lcnt && jn[p]) begin
            hold_r[p] <= cnt_r[HI];
         end
      end

      AST_WRAP32: assert property (@(posedge ref_clk) disable iff (srst)
         jn[p] && tick[LO] && m32[p] && !wr_en
         |=> cnt_r[LO] == 16'h0000 && cnt_r[HI] == 16'h0000)
         else $error("32-bit count did not wrap at period");
      AST_CARRY: assert property (@(posedge ref_clk) disable iff (srst)
         jn[p] && tick[LO] && !m32[p] && cnt_r[LO] == 16'hffff && !wr_en
         |=> cnt_r[HI] == $past(cnt_r[HI]) + 16'h0001 && cnt_r[LO] == 16'h0000)
         else $error("no carry into high half");
      AST_HOLD_RD: assert property (@(posedge ref_clk) disable iff (srst)
         rd_lcnt && jn[p] |=> hold_r[p] == $past(cnt_r[HI]))
         else $error("high half not latched on low read");
      AST_HOLD_WR: assert property (@(posedge ref_clk) disable iff (srst)
         wr_cnt[LO] && jn[p] |=> cnt_r[HI] == $past(hold_r[p]))
         else $error("held value not loaded into high half");
      AST_JOIN_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
         jn[p] && tick[LO] && m32[p] |=> stat_r[`DPT_IRQ_SHIFT + HI])
         else $error("joined match did not set high flag");
      AST_HI_CTL_IGN: assert property (@(posedge ref_clk) disable iff (srst)
         jn[p] && !wr_en && !tick[LO] |=> $stable(cnt_r[HI]))
         else $error("joined high half moved on its own");
   end

   // Interrupt status: set wins over the write-one clear
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stat_r <= 16'h0000;
      end else begin
         stat_r <= (stat_r & ~((wr_en && idx == `DPT_IDX_IRQ_STAT) ?
                   merge(16'h0000, wdat, wb_sel_i[1:0]) : 16'h0000)) |
                   ((16'(ev) << `DPT_IRQ_SHIFT) & `DPT_IRQ_MASK);
      end
   end

   // Interrupt enable mask
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         en_r <= 16'h0000;
      end else if (wr_en && idx == `DPT_IDX_IRQ_EN) begin
         en_r <= merge(en_r, wdat, wb_sel_i[1:0]) & `DPT_IRQ_MASK;
      end
   end

   assign irq_o = |(stat_r & en_r);

   // Converter trigger comes from the first pair only
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         trig_r <= 1'b0;
      end else begin
         trig_r <= jn[0] ? (tick[0] && m32[0]) :
                   (tick[1] && cnt_r[1] == per_r[1]);
      end
   end

   assign adc_trig_o = trig_r;
   // Time base for capture/compare: first pair only
   assign tb_a_low_o  = cnt_r[0];
   assign tb_a_high_o = cnt_r[1];

   AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (srst)
      irq_o |-> (stat_r[9:6] & en_r[9:6]) != 4'h0)
      else $error("interrupt without enabled flag");
   // An enabled event must raise the request in the next cycle
   AST_IRQ_RAISE: assert property (@(posedge ref_clk) disable iff (srst)
      (|(ev & en_r[9:6])) && !(wr_en && idx == `DPT_IDX_IRQ_EN) |=> irq_o)
      else $error("enabled event did not raise interrupt");
   AST_STICKY: assert property (@(posedge ref_clk) disable iff (srst)
      stat_r[7] && !(wr_en && idx == `DPT_IDX_IRQ_STAT) |=> stat_r[7])
      else $error("flag cleared without software");
   AST_TRIG_A: assert property (@(posedge ref_clk) disable iff (srst)
      adc_trig_o |-> $past(tick[0] || tick[1]))
      else $error("trigger without first pair match");
endmodule
`default_nettype wire

/* File: rtl/dptmr_defs.svh */
// Purpose: Constants of the dual pair 32-bit timer block.
// Assumes: Register index times four is the Wishbone byte address.
// Notes:   Included by the top module and the testbench.
// How it works
// - While the CPU sleeps no timer, prescaler or pair counts at all.
// - A joined pair sets its high flag on a 32-bit period match or a gate falling edge.
// - The interrupt output rises only for flags whose enable bit is set.
// - Each pair has a 16-bit holding register for the upper half, used when joined.
// - Only the first pair drives the converter trigger; the second pair has none.
// - Only the first pair's counts are offered as a capture/compare time base.
// - A joined second pair uses its low timer as the low 16 bits, high timer as top.
// - When joined, the high timer's control register is ignored for all setup.
// - When joined, the low timer's clock pin and gate pin drive the 32-bit count.
// - When joined, interrupts go through the high timer's flag and enable bit.
// - In 32-bit mode the count rises to the 32-bit period, then wraps to zero.
// - Reading the low count of a joined pair copies the high count into the holding register.
// - Writing the low count of a joined pair loads the held value into the high count.
// - In gated mode a gate falling edge stops counting and leaves the count as it is.
`ifndef DPTMR_DEFS_SVH
`define DPTMR_DEFS_SVH
`define DPT_IDX_A_LOW_CNT  10'h106
`define DPT_IDX_A_HOLD     10'h108
`define DPT_IDX_A_HIGH_CNT 10'h10a
`define DPT_IDX_A_LOW_PER  10'h10c
`define DPT_IDX_A_HIGH_PER 10'h10e
`define DPT_IDX_A_LOW_CON  10'h110
`define DPT_IDX_A_HIGH_CON 10'h112
`define DPT_IDX_B_LOW_CNT  10'h114
`define DPT_IDX_B_HOLD     10'h116
`define DPT_IDX_B_HIGH_CNT 10'h118
`define DPT_IDX_B_LOW_PER  10'h11a
`define DPT_IDX_B_HIGH_PER 10'h11c
`define DPT_IDX_B_LOW_CON  10'h11e
`define DPT_IDX_B_HIGH_CON 10'h120
`define DPT_IDX_IRQ_STAT   10'h084
`define DPT_IDX_IRQ_EN     10'h08c
`define DPT_IDX_NONE       10'h3ff
`define DPT_BIT_ON         15
`define DPT_BIT_IDLE       13
`define DPT_BIT_GATE       6
`define DPT_BIT_PS         4
`define DPT_BIT_JOIN       3
`define DPT_BIT_CS         1
`define DPT_CON_MASK_LO    16'ha07a
`define DPT_CON_MASK_HI    16'ha072
`define DPT_CON_RST        16'h0000
`define DPT_PER_RST        16'hffff
`define DPT_CNT_RST        16'h0000
`define DPT_IRQ_SHIFT      6
`define DPT_IRQ_MASK       16'h03c0
`define DPT_PS_T1          8'h00
`define DPT_PS_T8          8'h07
`define DPT_PS_T64         8'h3f
`define DPT_PS_T256        8'hff
`endif

/* File: rtl/dptmr_pkg.sv */
// Purpose: Types shared by the dual pair timer block.
// Assumes: Nothing beyond the constants header.
// Notes:   Prescale codes follow the two-bit select field order.
package dptmr_pkg;
   typedef logic [15:0] dptmr_word_t;
   typedef enum logic [1:0] {
      DPTMR_PS_1,
      DPTMR_PS_8,
      DPTMR_PS_64,
      DPTMR_PS_256
   } dptmr_ps_t;
endpackage

/* File: bench/tb_dual_pair_32bit_timer.sv */
// Purpose: Self-checking bench for the dual pair timer block.
// Assumes: Reads complete in order; each read pushes its expected word first.
// Notes:   Counting phases run only while cpu_sleep is low, so counts stay exact.
`timescale 1ns/1ps
`default_nettype none
`include "dptmr_defs.svh"
module tb_dual_pair_32bit_timer;
   import dptmr_pkg::*;
   `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
   logic        ref_clk, srst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [11:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, rnd, mexp;
   logic [3:0]  wb_sel_i;
   logic        cpu_sleep, cpu_idle, pair_a_ext_clock_pin, pair_a_high_pin;
   logic        pair_b_low_pin, pair_b_high_pin, irq_o, adc_trig_o;
   dptmr_word_t tb_a_low_o, tb_a_high_o;
   logic [15:0] exp_q[$];
   int          errors, checks_done, trig_cnt, t0;
   // Register indices with reset values, status and enable last
   logic [9:0]  idx_tab [0:15] = '{`DPT_IDX_A_LOW_CNT, `DPT_IDX_A_HOLD, `DPT_IDX_A_HIGH_CNT,
      `DPT_IDX_A_LOW_PER, `DPT_IDX_A_HIGH_PER, `DPT_IDX_A_LOW_CON, `DPT_IDX_A_HIGH_CON,
      `DPT_IDX_B_LOW_CNT, `DPT_IDX_B_HOLD, `DPT_IDX_B_HIGH_CNT, `DPT_IDX_B_LOW_PER,
      `DPT_IDX_B_HIGH_PER, `DPT_IDX_B_LOW_CON, `DPT_IDX_B_HIGH_CON, `DPT_IDX_IRQ_STAT,
      `DPT_IDX_IRQ_EN};
   logic [15:0] rst_tab [0:15] = '{16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'hffff,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'hffff, 16'h0000,
      16'h0000, 16'h0000, 16'h0000};
   logic [15:0] msk_tab [0:15] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
      16'ha07a, 16'ha072, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'ha07a,
      16'ha072, 16'h0000, 16'h03c0};

   dptmr_top dut (
      .ref_clk(ref_clk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
      .pair_a_ext_clock_pin(pair_a_ext_clock_pin), .pair_a_high_pin(pair_a_high_pin),
      .pair_b_low_pin(pair_b_low_pin), .pair_b_high_pin(pair_b_high_pin), .irq_o(irq_o),
      .adc_trig_o(adc_trig_o), .tb_a_low_o(tb_a_low_o), .tb_a_high_o(tb_a_high_o));

   // 25 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Pseudo-random words from a fixed starting value
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // One classic cycle; request held until ack is sampled high at an edge
   task automatic bus(input logic we, input logic [9:0] idx, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {16'h0000, d};
      wb_sel_i <= 4'h3;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) errors++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [15:0] d);
      bus(1'b1, idx, d);
   endtask

   // A read notes its expected word before the cycle starts
   task automatic rd(input logic [9:0] idx, input logic [15:0] e);
      exp_q.push_back(e);
      bus(1'b0, idx, 16'h0000);
   endtask

   // Timed counting phase; sleep freezes the block again afterwards
   task automatic run(input int n);
      cpu_sleep <= 1'b0;
      repeat (n) @(posedge ref_clk);
      cpu_sleep <= 1'b1;
   endtask

   // Monitor: read data is taken at the same edge that samples ack
   always @(posedge ref_clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, wb_dat_o, 32'h0);
         end else begin
            mexp = {16'h0000, exp_q.pop_front()};
            `CHK(wb_dat_o, mexp)
         end
      end
   end

   // Trigger pulses are counted so each phase can check its own share
   always @(posedge ref_clk) begin
      if (srst) trig_cnt <= 0;
      else if (adc_trig_o === 1'b1) trig_cnt <= trig_cnt + 1;
   end

   task automatic end_sim;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog sized well beyond the several hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      end_sim;
   end

   initial begin
      srst = 1'b1; wb_adr_i = 12'h000; wb_dat_i = 32'h0; wb_sel_i = 4'h0;
      wb_we_i = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; cpu_sleep = 1'b0;
      cpu_idle = 1'b0; pair_a_ext_clock_pin = 1'b0; pair_a_high_pin = 1'b0;
      pair_b_low_pin = 1'b0; pair_b_high_pin = 1'b0; errors = 0; checks_done = 0;
      rnd = 32'h24d9;
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      // Reset values, then an unmapped index that reads zero and ignores writes
      for (int i = 0; i < 16; i++) rd(idx_tab[i], rst_tab[i]);
      wr(`DPT_IDX_NONE, 16'hffff);
      rd(`DPT_IDX_NONE, 16'h0000);
      // Random words on counts, holds and periods, all-ones elsewhere, show writable bits; sleep keeps anything from counting
      cpu_sleep <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr_next(rnd);
         wr(idx_tab[i], (i < 5 || (i > 6 && i < 12)) ? rnd[15:0] : 16'hffff);
         rd(idx_tab[i], msk_tab[i] & ((i < 5 || (i > 6 && i < 12)) ? rnd[15:0] : 16'hffff));
         wr(idx_tab[i], (i == 3 || i == 4 || i == 10 || i == 11) ? 16'hffff : 16'h0000);
      end
      // Enabled timers hold still while asleep
      wr(`DPT_IDX_A_LOW_CON, 16'h8000);
      wr(`DPT_IDX_B_LOW_CON, 16'h8000);
      repeat (20) @(posedge ref_clk);
      rd(`DPT_IDX_A_LOW_CNT, 16'h0000);
      rd(`DPT_IDX_B_LOW_CNT, 16'h0000);
      // Four independent 16-bit timers, each with its own flag
      wr(`DPT_IDX_A_LOW_PER, 16'h0003);
      wr(`DPT_IDX_A_HIGH_PER, 16'h0005);
      wr(`DPT_IDX_B_LOW_PER, 16'h0004);
      wr(`DPT_IDX_B_HIGH_PER, 16'h0006);
      wr(`DPT_IDX_A_HIGH_CON, 16'h8000);
      wr(`DPT_IDX_B_HIGH_CON, 16'h8000);
      run(30);
      rd(`DPT_IDX_IRQ_STAT, 16'h03c0);
      for (int i = 5; i < 14; i++) if (msk_tab[i] != 16'hffff) wr(idx_tab[i], 16'h0000);
      // Flags stay set; the output follows only enabled flags
      `CHK(irq_o, 1'b0)
      wr(`DPT_IDX_IRQ_EN, 16'h0080);
      `CHK(irq_o, 1'b1)
      wr(`DPT_IDX_IRQ_EN, 16'h0400);
      `CHK(irq_o, 1'b0)
      rd(`DPT_IDX_IRQ_STAT, 16'h03c0);
      wr(`DPT_IDX_IRQ_EN, 16'h0080);
      wr(`DPT_IDX_IRQ_STAT, 16'h03c0);
      `CHK(irq_o, 1'b0)
      rd(`DPT_IDX_IRQ_STAT, 16'h0000);
      // Joined pair A: hold loads the high half, low read latches it back
      wr(`DPT_IDX_A_LOW_CON, 16'h0008);
      wr(`DPT_IDX_A_LOW_PER, 16'h0003);
      wr(`DPT_IDX_A_HIGH_PER, 16'h0001);
      wr(`DPT_IDX_A_HOLD, 16'h1234);
      wr(`DPT_IDX_A_LOW_CNT, 16'h0005);
      rd(`DPT_IDX_A_HIGH_CNT, 16'h1234);
      wr(`DPT_IDX_A_HOLD, 16'h0000);
      rd(`DPT_IDX_A_LOW_CNT, 16'h0005);
      rd(`DPT_IDX_A_HOLD, 16'h1234);
      `CHK(tb_a_low_o, 16'h0005)
      `CHK(tb_a_high_o, 16'h1234)
      wr(`DPT_IDX_A_HOLD, 16'h0001);
      wr(`DPT_IDX_A_LOW_CNT, 16'h0000);
      t0 = trig_cnt;
      wr(`DPT_IDX_A_LOW_CON, 16'h8008);
      run(12);
      rd(`DPT_IDX_IRQ_STAT, 16'h0080);
      rd(`DPT_IDX_A_HIGH_CNT, 16'h0000);
      `CHK(trig_cnt - t0, 1)
      wr(`DPT_IDX_A_LOW_CON, 16'h0000);
      wr(`DPT_IDX_IRQ_STAT, 16'h03c0);
      // Joined pair B with its high control left off: setup comes from the low one
      wr(`DPT_IDX_B_LOW_PER, 16'h0002);
      wr(`DPT_IDX_B_HIGH_PER, 16'h0000);
      wr(`DPT_IDX_B_HIGH_CNT, 16'h0000);
      wr(`DPT_IDX_B_LOW_CNT, 16'h0000);
      wr(`DPT_IDX_B_HIGH_CON, 16'h0030);
      wr(`DPT_IDX_B_LOW_CON, 16'h8008);
      t0 = trig_cnt;
      run(12);
      rd(`DPT_IDX_IRQ_STAT, 16'h0200);
      rd(`DPT_IDX_B_HIGH_CNT, 16'h0000);
      `CHK(trig_cnt - t0, 0)
      wr(`DPT_IDX_B_LOW_CON, 16'h0000);
      wr(`DPT_IDX_IRQ_STAT, 16'h03c0);
      // Gated accumulation: ten high cycles, then the falling edge stops and flags
      wr(`DPT_IDX_A_LOW_PER, 16'hffff);
      wr(`DPT_IDX_A_LOW_CNT, 16'h0000);
      wr(`DPT_IDX_A_LOW_CON, 16'h8040);
      cpu_sleep <= 1'b0;
      pair_a_ext_clock_pin <= 1'b1;
      repeat (10) @(posedge ref_clk);
      pair_a_ext_clock_pin <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd(`DPT_IDX_IRQ_STAT, 16'h0040);
      rd(`DPT_IDX_A_LOW_CNT, 16'h000a);
      repeat (10) @(posedge ref_clk);
      rd(`DPT_IDX_A_LOW_CNT, 16'h000a);
      wr(`DPT_IDX_A_LOW_CON, 16'h0000);
      // Second pair halts in idle with its halt bit set, and counts again once idle drops
      cpu_idle <= 1'b1;
      wr(`DPT_IDX_B_LOW_CNT, 16'h0000);
      wr(`DPT_IDX_B_LOW_CON, 16'ha000);
      repeat (10) @(posedge ref_clk);
      rd(`DPT_IDX_B_LOW_CNT, 16'h0000);
      cpu_idle <= 1'b0;
      run(2);
      rd(`DPT_IDX_B_LOW_CNT, 16'h0002);
      wr(`DPT_IDX_B_LOW_CON, 16'h0000);
      repeat (5) @(posedge ref_clk);
      if (exp_q.size() != 0) errors++;
      end_sim;
   end
endmodule
`default_nettype wire
